// file: core/reset_cause_pkg.sv
// Constants, types and register map of the system reset cause unit
package reset_cause_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses (low 16 address bits)
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_RESET_CAUSE_STATUS     = 16'hF600;
   localparam logic [15:0] ADDR_SOFTWARE_RESET_TRIGGER = 16'hF610;
   localparam logic [15:0] ADDR_UNLOCK_KEY             = 16'hF620;
   localparam logic [15:0] ADDR_IRQ_STATUS             = 16'hF630;
   localparam logic [15:0] ADDR_IRQ_MASK               = 16'hF640;

   // -----------------------------------------------------------------
   // Field positions of the reset cause status and software reset trigger registers
   // -----------------------------------------------------------------
   localparam int BIT_HIGH_VOLTAGE   = 29;
   localparam int BIT_CONFIG_MISM    = 9;
   localparam int BIT_REG_STANDBY    = 8;
   localparam int BIT_EXT_PIN        = 7;
   localparam int BIT_SOFT_RESET     = 6;
   localparam int BIT_WATCHDOG       = 4;
   localparam int BIT_SLEEP_WAKE     = 3;
   localparam int BIT_IDLE_WAKE      = 2;
   localparam int BIT_BROWNOUT       = 1;
   localparam int BIT_POWER_ON       = 0;
   localparam int BIT_TRIGGER        = 0;

   localparam logic [31:0] STATUS_IMPL_MASK = 32'h2000_03DF;
   localparam logic [31:0] STATUS_HS_MASK   = 32'h2000_02DF;
   localparam logic [31:0] STATUS_POR_VALUE = 32'h0000_0003;
   localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

   // Unlock keys, arbitrary values
   localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'h1234_ABCD;
   localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hCDAB_3412;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_HOLD_NS   = 100;
   localparam int RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Asynchronous reset sources and wake events, one bit each
   typedef struct packed {
      logic high_voltage;
      logic config_mismatch;
      logic brownout;
      logic watchdog;
      logic ext_clear_n;
      logic sleep_entered;
      logic idle_entered;
   } reset_cause_t;

   typedef enum logic [1:0] {
      LOCK_CLOSED = 2'b00,
      LOCK_HALF   = 2'b01,
      LOCK_OPEN   = 2'b10
   } unlock_state_t;

endpackage

// file: core/system_reset_cause_unit.sv
// Reset cause unit: merges reset sources, records causes, AHB-Lite registers
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module system_reset_cause_unit
   import reset_cause_pkg::*;
#(
   parameter int HOLD_CYC = RST_HOLD_CYC
)
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_nrst,
   input  wire reset_cause_t  i_causes,
   input  wire logic          i_regulator_fuse,
   input  wire logic          i_hsel,
   input  wire logic [31:0]   i_haddr,
   input  wire logic [1:0]    i_htrans,
   input  wire logic          i_hwrite,
   input  wire logic [2:0]    i_hsize,
   input  wire logic [31:0]   i_hwdata,
   input  wire logic          i_hready,
   output logic               o_hreadyout,
   output logic               o_hresp,
   output logic [31:0]        o_hrdata,
   output logic               o_master_system_reset,
   output logic               o_regulator_standby_enable,
   output logic               o_irq
);

   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYC);
   localparam logic [HW-1:0] HOLD_ZERO = '0;

   // -----------------------------------------------------------------
   // Decoding helper
   // -----------------------------------------------------------------
   // Maps a vector of cause events onto status register positions
   function automatic logic [31:0] cause_flags(input reset_cause_t c);
      logic [31:0] f;
      f                    = ZERO_WORD;
      f[BIT_HIGH_VOLTAGE]  = c.high_voltage;
      f[BIT_CONFIG_MISM]   = c.config_mismatch;
      f[BIT_BROWNOUT]      = c.brownout;
      f[BIT_WATCHDOG]      = c.watchdog;
      f[BIT_EXT_PIN]       = c.ext_clear_n;
      f[BIT_SLEEP_WAKE]    = c.sleep_entered;
      f[BIT_IDLE_WAKE]     = c.idle_entered;
      return f;
   endfunction

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   reset_cause_t  sync1_r;
   reset_cause_t  sync2_r;
   reset_cause_t  prev_r;
   reset_cause_t  level;
   reset_cause_t  rise;
   logic          src_active;

   // Detectors and pin are asynchronous; two stages before any use
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end
      else
      begin
         sync1_r <= {i_causes.high_voltage, i_causes.config_mismatch, i_causes.brownout,
                     i_causes.watchdog, ~i_causes.ext_clear_n, i_causes.sleep_entered,
                     i_causes.idle_entered};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Active-high levels (pin already inverted) and their rising edges
   assign level      = sync2_r;
   assign rise       = level & ~prev_r;
   assign src_active = level.high_voltage | level.config_mismatch | level.brownout |
                       level.watchdog | level.ext_clear_n;

   // -----------------------------------------------------------------
   // AHB-Lite slave
   // -----------------------------------------------------------------
   logic          dp_valid_r;
   logic          dp_write_r;
   logic          rd_wait_r;
   logic [15:0]   dp_addr_r;
   logic          addr_take;
   logic          wr_en;
   logic          wr_status;
   logic          wr_trigger;
   logic          wr_key;
   logic          wr_irq_status;
   logic          wr_irq_mask;
   logic [31:0]   rdata_nxt;

   assign addr_take     = i_hsel & i_htrans[1] & i_hready;
   assign wr_en         = dp_valid_r & dp_write_r;
   assign wr_status     = wr_en & (dp_addr_r == ADDR_RESET_CAUSE_STATUS);
   assign wr_trigger    = wr_en & (dp_addr_r == ADDR_SOFTWARE_RESET_TRIGGER);
   assign wr_key        = wr_en & (dp_addr_r == ADDR_UNLOCK_KEY);
   assign wr_irq_status = wr_en & (dp_addr_r == ADDR_IRQ_STATUS);
   assign wr_irq_mask   = wr_en & (dp_addr_r == ADDR_IRQ_MASK);

   // Reads take one wait state so a read right after a write sees it
   assign o_hreadyout = ~(dp_valid_r & ~dp_write_r & ~rd_wait_r);
   assign o_hresp     = 1'b0;

   // Address phase capture, only full words are meaningful
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r  <= 16'h0000;
         rd_wait_r  <= 1'b0;
      end
      else
      begin
         if (o_hreadyout)
         begin
            dp_valid_r <= addr_take;
            dp_write_r <= i_hwrite;
            dp_addr_r  <= {i_haddr[15:2], 2'b00};
            rd_wait_r  <= 1'b0;
         end
         else
         begin
            rd_wait_r  <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Unlock sequence and software reset trigger
   // -----------------------------------------------------------------
   unlock_state_t lock_r;
   logic          swr_event;

   // Trigger is write-only with no storage: it acts for one cycle
   assign swr_event = wr_trigger & (lock_r == LOCK_OPEN) & i_hwdata[BIT_TRIGGER];

   // Two consecutive key writes open the lock for one trigger write
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         lock_r <= LOCK_CLOSED;
      end
      else if (o_master_system_reset || wr_trigger)
      begin
         lock_r <= LOCK_CLOSED;
      end
      else if (wr_key)
      begin
         case (lock_r)
            LOCK_CLOSED : lock_r <= (i_hwdata == UNLOCK_KEY_FIRST) ? LOCK_HALF : LOCK_CLOSED;
            LOCK_HALF   : lock_r <= (i_hwdata == UNLOCK_KEY_SECOND) ? LOCK_OPEN : LOCK_CLOSED;
            default     : lock_r <= LOCK_CLOSED;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Master system reset
   // -----------------------------------------------------------------
   logic [HW-1:0] hold_cnt_r;
   logic          master_r;

   // Stretches every reset source and the software trigger (not sleep or idle) so the chip sees a clean, long enough pulse
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         hold_cnt_r <= HOLD_LOAD;
         master_r   <= 1'b1;
      end
      else
      begin
         if (src_active || swr_event)
         begin
            hold_cnt_r <= HOLD_LOAD;
         end
         else if (hold_cnt_r != HOLD_ZERO)
         begin
            hold_cnt_r <= hold_cnt_r - 1'b1;
         end
         master_r <= src_active | swr_event | (hold_cnt_r != HOLD_ZERO);
      end
   end

   assign o_master_system_reset = master_r;

   // -----------------------------------------------------------------
   // Reset cause status register
   // -----------------------------------------------------------------
   logic [31:0]   status_r;
   logic [31:0]   status_nxt;
   logic [31:0]   set_flags;
   logic          fuse_done_r;

   // Only the flag of the cause that fired is set
   always_comb
   begin
      set_flags                  = cause_flags(rise);
      set_flags[BIT_SOFT_RESET]  = swr_event;
   end

   // Software write first, hardware set wins over it
   always_comb
   begin
      status_nxt = status_r;
      if (wr_status)
      begin
         status_nxt = i_hwdata & STATUS_IMPL_MASK;
      end
      if (!fuse_done_r)
      begin
         status_nxt[BIT_REG_STANDBY] = i_regulator_fuse;
      end
      status_nxt = status_nxt | (set_flags & STATUS_HS_MASK);
   end

   // Not reset by the master reset: the causes must survive it
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         status_r    <= STATUS_POR_VALUE;
         fuse_done_r <= 1'b0;
      end
      else
      begin
         status_r    <= status_nxt;
         fuse_done_r <= 1'b1;
      end
   end

   assign o_regulator_standby_enable = status_r[BIT_REG_STANDBY];

   // -----------------------------------------------------------------
   // Interrupt status and mask
   // -----------------------------------------------------------------
   logic [31:0]   irq_status_r;
   logic [31:0]   irq_mask_r;

   // Same layout as the cause flags; write one to clear, set wins
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         irq_status_r <= ZERO_WORD;
         irq_mask_r   <= ZERO_WORD;
      end
      else
      begin
         irq_status_r <= ((wr_irq_status ? (irq_status_r & ~i_hwdata) : irq_status_r) |
                          set_flags) & STATUS_HS_MASK;
         if (wr_irq_mask)
         begin
            irq_mask_r <= i_hwdata & STATUS_HS_MASK;
         end
      end
   end

   // Level output
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= |(irq_status_nxt_w() & irq_mask_r);
      end
   end

   function automatic logic [31:0] irq_status_nxt_w();
      return irq_status_r;
   endfunction

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   // Trigger and key registers are write-only and read zero
   always_comb
   begin
      if (dp_addr_r == ADDR_RESET_CAUSE_STATUS)
      begin
         rdata_nxt = status_r & STATUS_IMPL_MASK;
      end
      else if (dp_addr_r == ADDR_IRQ_STATUS)
      begin
         rdata_nxt = irq_status_r;
      end
      else if (dp_addr_r == ADDR_IRQ_MASK)
      begin
         rdata_nxt = irq_mask_r;
      end
      else
      begin
         rdata_nxt = ZERO_WORD;
      end
   end

   // Loaded in the wait cycle of a read data phase
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_hrdata <= ZERO_WORD;
      end
      else if (dp_valid_r && !dp_write_r && !rd_wait_r)
      begin
         o_hrdata <= rdata_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   sequence soft_req_s;
      wr_trigger && lock_r == LOCK_OPEN && i_hwdata[BIT_TRIGGER];
   endsequence

   sequence hold_high_s;
      o_master_system_reset [*8];
   endsequence

   master_hold_a : assert property (soft_req_s |=> hold_high_s)
      else $error("master reset not held after software reset");
   soft_flag_a : assert property (soft_req_s |=> status_r[BIT_SOFT_RESET])
      else $error("soft reset flag not set");
   locked_ignore_a : assert property (wr_trigger && lock_r != LOCK_OPEN && !src_active
      && hold_cnt_r == HOLD_ZERO |=> !o_master_system_reset)
      else $error("trigger acted while locked");
   hv_flag_a : assert property ($rose(level.high_voltage) |=> status_r[BIT_HIGH_VOLTAGE])
      else $error("high voltage flag not set");
   mism_flag_a : assert property ($rose(level.config_mismatch) |=> status_r[BIT_CONFIG_MISM])
      else $error("mismatch flag not set");
   pin_flag_a : assert property ($rose(level.ext_clear_n) |=> status_r[BIT_EXT_PIN])
      else $error("clear pin flag not set");
   wdt_flag_a : assert property ($rose(level.watchdog) |=> status_r[BIT_WATCHDOG] &&
      o_master_system_reset)
      else $error("watchdog flag or reset missing");
   sleep_flag_a : assert property ($rose(level.sleep_entered) |=> status_r[BIT_SLEEP_WAKE])
      else $error("sleep flag not set");
   idle_flag_a : assert property ($rose(level.idle_entered) |=> status_r[BIT_IDLE_WAKE])
      else $error("idle flag not set");
   bor_flag_a : assert property ($rose(level.brownout) |=> status_r[BIT_BROWNOUT])
      else $error("brownout flag not set");
   sticky_flags_a : assert property (status_r[BIT_POWER_ON] && !wr_status
      |=> status_r[BIT_POWER_ON])
      else $error("power-on flag dropped without a write");
   regstby_hw_a : assert property (!wr_status && fuse_done_r && !status_r[BIT_REG_STANDBY]
      |=> !o_regulator_standby_enable)
      else $error("regulator standby set by hardware");
   unimpl_zero_a : assert property ((status_r & ~STATUS_IMPL_MASK) == ZERO_WORD)
      else $error("unimplemented status bit set");
   only_own_a : assert property (!wr_status && fuse_done_r && !rise.watchdog
      |=> status_r[BIT_WATCHDOG] == $past(status_r[BIT_WATCHDOG]))
      else $error("watchdog flag changed without its cause");

endmodule // system_reset_cause_unit

// file: tb/reset_source_model.sv
// Behavioural model of the reset sources that sit outside the cause unit
`timescale 1ns/1ps
module reset_source_model
   import reset_cause_pkg::*;
#(
   parameter int PULSE_CYC = 3
)
(
   input  wire logic         i_ref_clk,
   input  wire logic [6:0]   i_fire,
   output reset_cause_t      o_causes
);
   // -----------------------------------------------------------------
   // Source levels
   // -----------------------------------------------------------------
   logic [6:0] active_r = 7'h00;
   logic [3:0] cnt_r    = 4'h0;

   // Each requested source holds its level for a few cycles, like a detector
   always_ff @(posedge i_ref_clk)
   begin
      if (i_fire != 7'h00)
      begin
         active_r <= i_fire;
         cnt_r    <= 4'(PULSE_CYC);
      end
      else if (cnt_r != 4'h0)
      begin
         cnt_r <= cnt_r - 4'h1;
         if (cnt_r == 4'h1)
         begin
            active_r <= 7'h00;
         end
      end
   end

   // Clear pin idles high and pulls low when pressed
   assign o_causes = reset_cause_t'(active_r ^ 7'h04);
endmodule // reset_source_model

// file: tb/tb_system_reset_cause_unit.sv
// Self-checking testbench of the system reset cause unit
`timescale 1ns/1ps
module tb_system_reset_cause_unit;
   import reset_cause_pkg::*;

   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam int HOLD         = 8;
   localparam int FLAG_POS [7] = '{2, 3, 7, 4, 1, 9, 29};
   logic          clk;
   logic          nrst;
   logic          fuse;
   logic          hsel;
   logic [31:0]   haddr;
   logic [1:0]    htrans;
   logic          hwrite;
   logic [2:0]    hsize;
   logic [31:0]   hwdata;
   wire logic     hready;
   logic          hresp;
   logic [31:0]   hrdata;
   logic          sys_rst;
   logic          reg_stby;
   logic          irq;
   logic [6:0]    fire;
   reset_cause_t  causes;
   logic [31:0]   rd;
   int            bad_count;
   int            n_tests;
   int            n;

   system_reset_cause_unit #(.HOLD_CYC(HOLD)) system_reset_cause_unit_inst (
      .i_ref_clk                  (clk),
      .i_nrst                     (nrst),
      .i_causes                   (causes),
      .i_regulator_fuse           (fuse),
      .i_hsel                     (hsel),
      .i_haddr                    (haddr),
      .i_htrans                   (htrans),
      .i_hwrite                   (hwrite),
      .i_hsize                    (hsize),
      .i_hwdata                   (hwdata),
      .i_hready                   (hready),
      .o_hreadyout                (hready),
      .o_hresp                    (hresp),
      .o_hrdata                   (hrdata),
      .o_master_system_reset      (sys_rst),
      .o_regulator_standby_enable (reg_stby),
      .o_irq                      (irq)
   );

   reset_source_model reset_source_model_inst (
      .i_ref_clk (clk),
      .i_fire    (fire),
      .o_causes  (causes)
   );

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic final_report;
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for the slave; a hang ends the run
   task automatic wait_ready;
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (hready !== 1'b1 && k < 64);
      if (hready !== 1'b1)
      begin
         check("bus wait", 32'h1, 32'h0);
         final_report();
      end
   endtask

   // One AHB-Lite single word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {16'h0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, exp, rd);
   endtask

   // Counts edges until the master reset drops, bounded
   task automatic wait_low(output int cnt);
      cnt = 0;
      while (sys_rst !== 1'b0 && cnt < 64)
      begin
         @(posedge clk);
         cnt++;
      end
      if (sys_rst !== 1'b0)
      begin
         check("reset wait", 32'h0, 32'h1);
         final_report();
      end
   endtask

   // Pulse one source through the model, then let its reset run out
   task automatic fire_src(input int i);
      fire <= 7'(1 << i);
      @(posedge clk);
      fire <= 7'h00;
      repeat (6) @(posedge clk);
      check("reset out", {31'h0, i >= 2}, {31'h0, sys_rst});
      wait_low(n);
   endtask

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      nrst      <= 1'b0;
      fuse      <= 1'b1;
      hsel      <= 1'b0;
      haddr     <= 32'h0000_0000;
      htrans    <= 2'b00;
      hwrite    <= 1'b0;
      hsize     <= 3'b010;
      hwdata    <= 32'h0000_0000;
      fire      <= 7'h00;
      bad_count = 0;
      n_tests   = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("reset out", 32'h1, {31'h0, sys_rst});
      rdchk("status at power-on", ADDR_RESET_CAUSE_STATUS, 32'h0000_0103);
      check("regulator fuse", 32'h1, {31'h0, reg_stby});
      wait_low(n);
      check("hold time", 32'h1, {31'h0, (n + 4 >= HOLD) && (n + 4 <= HOLD + 2)});
      // Flags clear by software and only implemented bits stick
      wr(ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      rdchk("status cleared", ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      check("regulator off", 32'h0, {31'h0, reg_stby});
      wr(ADDR_RESET_CAUSE_STATUS, 32'hFFFF_FFFF);
      rdchk("status ones", ADDR_RESET_CAUSE_STATUS, STATUS_IMPL_MASK);
      check("regulator on", 32'h1, {31'h0, reg_stby});
      wr(ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      // Unmapped and write-only places read zero
      wr(16'hF6F0, 32'hFFFF_FFFF);
      rdchk("unmapped", 16'hF6F0, 32'h0000_0000);
      rdchk("status kept", ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      rdchk("trigger read", ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0000);
      // Every source sets its own flag only
      for (int i = 0; i < 7; i++)
      begin
         fire_src(i);
         rdchk("cause flag", ADDR_RESET_CAUSE_STATUS, 32'h1 << FLAG_POS[i]);
         wr(ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      end
      // Trigger without unlock, then a zero write that relocks
      wr(ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("locked trigger", 32'h0, {31'h0, sys_rst});
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_FIRST);
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_SECOND);
      wr(ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0000);
      wr(ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("zero trigger", 32'h0, {31'h0, sys_rst});
      rdchk("no soft flag", ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      // Proper unlock followed by the trigger
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_FIRST);
      wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_SECOND);
      wr(ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0001);
      @(posedge clk);
      check("soft reset", 32'h1, {31'h0, sys_rst});
      wait_low(n);
      check("soft hold", 32'h1, {31'h0, (n >= HOLD) && (n <= HOLD + 2)});
      rdchk("soft flag", ADDR_RESET_CAUSE_STATUS, 32'h0000_0040);
      rdchk("trigger self-clear", ADDR_SOFTWARE_RESET_TRIGGER, 32'h0000_0000);
      wr(ADDR_RESET_CAUSE_STATUS, 32'h0000_0000);
      // Interrupt: raise masked, unmask, clear by writing one
      wr(ADDR_IRQ_STATUS, 32'hFFFF_FFFF);
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      fire_src(3);
      check("irq masked", 32'h0, {31'h0, irq});
      rdchk("irq status", ADDR_IRQ_STATUS, 32'h0000_0010);
      wr(ADDR_IRQ_MASK, 32'h0000_0010);
      repeat (2) @(posedge clk);
      check("irq raised", 32'h1, {31'h0, irq});
      wr(ADDR_IRQ_STATUS, 32'h0000_0010);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, {31'h0, irq});
      rdchk("irq status cleared", ADDR_IRQ_STATUS, 32'h0000_0000);
      check("response", 32'h0, {31'h0, hresp});
      final_report();
   end
endmodule // tb_system_reset_cause_unit
